// ==== design/urx_pkg.sv ====
// Constants and types shared by the asynchronous receive front end.
// Assumes a 32-bit AXI4-Lite register bus with 12 address bits.
package urx_pkg;
   // Register byte addresses
   localparam logic [11:0] URX_CTRL_OFS   = 12'h000;
   localparam logic [11:0] URX_BAUD_OFS   = 12'h004;
   localparam logic [11:0] URX_STATUS_OFS = 12'h008;
   localparam logic [11:0] URX_DATA_OFS   = 12'h00C;
   // Control field positions
   localparam int URX_CTRL_RXEN  = 0;
   localparam int URX_CTRL_DS    = 1;
   localparam int URX_CTRL_SDET  = 2;
   localparam int URX_CTRL_SIE   = 3;
   localparam int URX_CTRL_CSZ   = 4;
   localparam int URX_CTRL_PEN   = 7;
   localparam int URX_CTRL_PODD  = 8;
   // Status field positions
   localparam int URX_ST_FULL    = 0;
   localparam int URX_ST_FERR    = 1;
   localparam int URX_ST_PERR    = 2;
   localparam int URX_ST_OVR     = 3;
   localparam int URX_ST_START   = 4;
   localparam int URX_ST_BUSY    = 5;
   // Reset values
   localparam logic [8:0]  URX_CTRL_RST = 9'h030;
   localparam logic [11:0] URX_BAUD_RST = 12'h00C;
   // Samples per bit and first voting sample
   localparam logic [4:0] URX_SPB_NORM = 5'h10;
   localparam logic [4:0] URX_SPB_DBL  = 5'h08;
   localparam logic [4:0] URX_SF_NORM  = 5'h08;
   localparam logic [4:0] URX_SF_DBL   = 5'h04;
   localparam logic [3:0] URX_MIN_CHAR = 4'h5;
   // AXI responses
   localparam logic [1:0] URX_OKAY   = 2'b00;
   localparam logic [1:0] URX_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_DATA  = 2'b10,
      ST_STOP  = 2'b11
   } urx_state_t;
endpackage : urx_pkg

// ==== design/urx_samp_if.sv ====
// Carrier between the sample-clock generator and the receiver core.
// Assumes both ends run on the same aclk.
`timescale 1ns/100ps
`default_nettype none
interface urx_samp_if;
   logic        tick;      // One-cycle sample strobe
   logic        rx_level;  // Synchronised serial input
   logic [11:0] divisor;   // Sample period minus one
   modport gen (output tick, output rx_level, input divisor);
   modport use_side (input tick, input rx_level, output divisor);
endinterface : urx_samp_if
`default_nettype wire

// ==== design/urx_sampler.sv ====
// Input synchroniser and sample-strobe divider for the receiver.
// Assumes rx_pin is asynchronous to aclk.
`timescale 1ns/100ps
`default_nettype none
module urx_sampler
   import urx_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic rx_pin,
   urx_samp_if.gen   sp
);
   logic [2:0]  sync;
   logic [11:0] div_cnt;
   wire         agree = (sync[1] == sync[2]);

   // Three-stage capture; level follows once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync        <= 3'h7;
         sp.rx_level <= 1'b1;
      end else begin
         sync <= {sync[1:0], rx_pin};
         if (agree) begin
            sp.rx_level <= sync[2];
         end
      end
   end

   // Divider: one strobe every divisor+1 clocks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt <= 12'h000;
         sp.tick <= 1'b0;
      end else begin
         sp.tick <= (div_cnt == 12'h000);
         div_cnt <= (div_cnt == 12'h000) ? sp.divisor : div_cnt - 12'h001;
      end
   end
endmodule : urx_sampler
`default_nettype wire

// ==== design/urx_receiver.sv ====
// Asynchronous receive front end with start-frame detector and AXI4-Lite registers.
// Assumes a single 20 MHz aclk; rx_pin is asynchronous to it.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Sample at 16x baud normally, 8x baud in double speed mode.
// - Idle-high to low edge starts start detection; first low sample is one.
// - Start validity from samples 8,9,10 normal or 4,5,6 double speed.
// - Two or more high decision samples reject start; resume edge watch.
// - Accepted start realigns bit timing; repeated for every start bit.
// - Recovery steps sixteen states per bit normal, eight double speed.
// - Each data, parity, stop bit resolved by majority of three centre samples.
// - Vote window starts sample 8 (middle 9), or 4 (middle 5) double.
// - Recover through first stop bit; further stop bits are ignored.
// - Stop bit voted like others; low stop sets framing error flag.
// - Next start edge detectable right after last stop vote sample.
// - Character plus parity length of five to ten bits supported.
// - With detection active, falling edge powers oscillator and port clock.
// - Start detection enabled by start_detect_enable, in both modes.
// - With start_irq_enable set, start interrupt raised at once on detection.
// - Without start interrupt, clocks run only while the frame is received.
// - Framing error stored with its frame: zero for stop one, one otherwise.
module urx_receiver
   import urx_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        rx_pin,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             osc_power_req,
   output logic             port_clk_en,
   output logic             start_irq
);
   urx_samp_if sp ();

   urx_sampler u_sampler (
      .aclk    (aclk),
      .aresetn (aresetn),
      .rx_pin  (rx_pin),
      .sp      (sp.gen)
   );

   // Software state
   logic [8:0]  ctrl;
   logic [11:0] baud_divisor;
   logic        start_seen;
   logic        overrun;
   // Receive entry
   logic        rx_full;
   logic [8:0]  rx_char;
   logic        framing_error_flag;
   logic        parity_error;
   // Recovery state
   urx_state_t  state;
   urx_state_t  next_state;
   logic [4:0]  smp;
   logic [3:0]  bit_idx;
   logic [9:0]  frame_bits;
   logic [1:0]  votes;
   logic        rx_prev;
   logic        lvl_prev;
   logic        wake;

   assign sp.divisor = baud_divisor;

   // Control fields
   wire        rx_enable           = ctrl[URX_CTRL_RXEN];
   wire        double_speed_select = ctrl[URX_CTRL_DS];
   wire        start_detect_enable = ctrl[URX_CTRL_SDET];
   wire        start_irq_enable    = ctrl[URX_CTRL_SIE];
   wire        par_en              = ctrl[URX_CTRL_PEN];
   wire        par_odd             = ctrl[URX_CTRL_PODD];
   wire [3:0]  n_char  = URX_MIN_CHAR + {1'b0, ctrl[URX_CTRL_CSZ +: 3]};
   wire [3:0]  n_bits  = n_char + {3'h0, par_en};
   wire [4:0]  spb     = double_speed_select ? URX_SPB_DBL : URX_SPB_NORM;
   wire [4:0]  sf      = double_speed_select ? URX_SF_DBL : URX_SF_NORM;
   wire [4:0]  vote_end = sf + 5'h02;

   // Sampling decode
   wire        tick    = sp.tick;
   wire        rx_s    = sp.rx_level;
   wire        fall    = rx_prev & ~rx_s;
   wire        maj3    = (votes[0] & votes[1]) | (votes[0] & rx_s) | (votes[1] & rx_s);
   wire        at_vote = (smp == vote_end);
   wire        at_end  = (smp == spb);
   wire        last_bit = (bit_idx == n_bits - 4'h1);
   wire        busy    = (state != ST_IDLE);

   // Next recovery state on each sample strobe
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (fall) begin
               next_state = ST_START;
            end
         end
         ST_START: begin
            if (at_vote && maj3) begin
               next_state = ST_IDLE;
            end else if (at_end) begin
               next_state = ST_DATA;
            end
         end
         ST_DATA: begin
            if (at_end && last_bit) begin
               next_state = ST_STOP;
            end
         end
         ST_STOP: begin
            if (at_vote) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // Frame result decode
   wire        frame_done = tick & (state == ST_STOP) & at_vote;
   wire [9:0]  char_mask  = ~(10'h3FF << n_char);
   wire [8:0]  char_word  = frame_bits[8:0] & char_mask[8:0];
   wire        par_bit    = frame_bits[n_char];
   wire        par_bad    = par_en & (^char_word ^ par_bit ^ par_odd);

   // Recovery machine and sample counter
   always_ff @(posedge aclk) begin
      if (!aresetn || !rx_enable) begin
         state   <= ST_IDLE;
         smp     <= 5'h00;
         bit_idx <= 4'h0;
         rx_prev <= 1'b1;
         votes   <= 2'b11;
      end else if (tick) begin
         state   <= next_state;
         rx_prev <= rx_s;
         votes   <= {votes[0], rx_s};
         if (state == ST_IDLE) begin
            smp     <= 5'h02; // first low sample is one, next is two
            bit_idx <= 4'h0;
         end else if (at_end) begin
            smp <= 5'h01;
         end else begin
            smp <= smp + 5'h01;
         end
         if (state == ST_DATA && at_end) begin
            bit_idx <= bit_idx + 4'h1;
         end
      end
   end

   // Bit store at the last voting sample
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_bits <= 10'h000;
      end else if (tick && state == ST_DATA && at_vote) begin
         frame_bits[bit_idx] <= maj3;
      end
   end

   // AXI4-Lite decode
   wire        aw_go  = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
   wire        wr_go  = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
   wire        ar_go  = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
   wire        rd_go  = s_axi_arready & s_axi_arvalid;
   wire [31:0] wmask  = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                         {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
   wire        wr_ctrl = wr_go & (s_axi_awaddr == URX_CTRL_OFS);
   wire        wr_baud = wr_go & (s_axi_awaddr == URX_BAUD_OFS);
   wire        wr_stat = wr_go & (s_axi_awaddr == URX_STATUS_OFS);
   wire        wr_hit  = (s_axi_awaddr == URX_CTRL_OFS) | (s_axi_awaddr == URX_BAUD_OFS)
                       | (s_axi_awaddr == URX_STATUS_OFS);
   wire        rd_data = rd_go & (s_axi_araddr == URX_DATA_OFS);
   wire [31:0] ctrl_new = ({23'h0, ctrl} & ~wmask) | (s_axi_wdata & wmask);
   wire [31:0] baud_new = ({20'h0, baud_divisor} & ~wmask) | (s_axi_wdata & wmask);
   wire [31:0] clr_bits = s_axi_wdata & wmask;
   wire [31:0] status_word = {26'h0, busy, start_seen, overrun, parity_error,
                              framing_error_flag, rx_full};
   wire        rd_hit  = (s_axi_araddr == URX_CTRL_OFS) | (s_axi_araddr == URX_BAUD_OFS)
                       | (s_axi_araddr == URX_STATUS_OFS) | (s_axi_araddr == URX_DATA_OFS);
   wire [31:0] rd_word = (s_axi_araddr == URX_CTRL_OFS)   ? {23'h0, ctrl} :
                         (s_axi_araddr == URX_BAUD_OFS)   ? {20'h0, baud_divisor} :
                         (s_axi_araddr == URX_STATUS_OFS) ? status_word :
                         (s_axi_araddr == URX_DATA_OFS)   ? {23'h0, rx_char} : 32'h0;

   // Write channel handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= URX_OKAY;
      end else begin
         s_axi_awready <= aw_go;
         s_axi_wready  <= aw_go;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? URX_OKAY : URX_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= URX_OKAY;
      end else begin
         s_axi_arready <= ar_go;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? URX_OKAY : URX_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Control and divisor registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl         <= URX_CTRL_RST;
         baud_divisor <= URX_BAUD_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl <= ctrl_new[8:0];
         end
         if (wr_baud) begin
            baud_divisor <= baud_new[11:0];
         end
      end
   end

   // Receive entry; a new frame wins over a data read in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn || !rx_enable) begin
         rx_full            <= 1'b0;
         rx_char            <= 9'h000;
         framing_error_flag <= 1'b0;
         parity_error       <= 1'b0;
      end else if (frame_done) begin
         rx_full            <= 1'b1;
         rx_char            <= char_word;
         framing_error_flag <= ~maj3;
         parity_error       <= par_bad;
      end else if (rd_data) begin
         rx_full <= 1'b0;
      end
   end

   // Start-frame detector; only a fall on the idle line counts as a start
   wire lvl_fall   = lvl_prev & ~rx_s & ~busy;
   wire frame_off  = tick & busy & (next_state == ST_IDLE);
   // Wake holds only while a frame is under way; with start_irq_enable set the start flag holds power alone
   wire next_wake  = start_detect_enable & (lvl_fall | (wake & ~frame_off & rx_enable));
   wire next_power = next_wake | (start_detect_enable & start_irq_enable & start_seen);

   // Sticky overrun and start flags, write one to clear, set wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overrun    <= 1'b0;
         start_seen <= 1'b0;
      end else begin
         overrun    <= (frame_done & rx_full & ~rd_data)
                       | (overrun & ~(wr_stat & clr_bits[URX_ST_OVR]));
         start_seen <= (start_detect_enable & lvl_fall)
                       | (start_seen & ~(wr_stat & clr_bits[URX_ST_START]));
      end
   end

   // Start-frame detector outputs, updated on every clock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lvl_prev      <= 1'b1;
         wake          <= 1'b0;
         osc_power_req <= 1'b0;
         port_clk_en   <= 1'b0;
         start_irq     <= 1'b0;
      end else begin
         lvl_prev      <= rx_s;
         wake          <= next_wake;
         osc_power_req <= next_power;
         port_clk_en   <= next_power;
         start_irq     <= start_detect_enable & start_irq_enable & lvl_fall;
      end
   end

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_sample_rate: assert property (
      busy |-> smp <= (double_speed_select ? 5'h08 : 5'h10))
      else $error("samples per bit wrong");
   a_start_begin: assert property (
      rx_enable && tick && state == ST_IDLE && fall |=> state == ST_START && smp == 5'h02)
      else $error("start edge not taken");
   a_start_reject: assert property (
      rx_enable && tick && state == ST_START && at_vote && maj3 |=> state == ST_IDLE)
      else $error("noise start not rejected");
   a_vote_window: assert property (
      vote_end == (double_speed_select ? 5'h06 : 5'h0A))
      else $error("vote window misplaced");
   a_count_range: assert property (
      state != ST_IDLE |-> smp >= 5'h01 && smp <= spb)
      else $error("sample counter out of range");
   a_stop_end: assert property (
      rx_enable && tick && state == ST_STOP && at_vote |=> state == ST_IDLE && rx_full)
      else $error("stop bit not closing frame");
   a_frame_error: assert property (
      frame_done |=> framing_error_flag == $past(~maj3))
      else $error("framing error not stored");
   a_osc_wake: assert property (
      start_detect_enable && lvl_fall |=> osc_power_req && port_clk_en)
      else $error("oscillator not woken");
   a_start_irq: assert property (
      start_detect_enable && start_irq_enable && lvl_fall |=> start_irq ##1 !start_irq)
      else $error("start interrupt not pulsed");
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
endmodule : urx_receiver
`default_nettype wire

// ==== verification/urx_tx_model.sv ====
// Behavioural remote serial transmitter driving the receive line.
// Assumes the bench calls its tasks one at a time, timed on aclk.
`timescale 1ns/100ps
`default_nettype none
module urx_tx_model (
   input  wire logic aclk,
   output logic      rx_line
);
   // Line idles high between frames
   initial rx_line = 1'b1;

   // Start, n bits LSB first, then stop; rate is an exact aclk multiple
   task automatic send(input logic [9:0] bits, input int n, input int blen, input int slen,
                       input logic stop_val, input int gl);
      @(posedge aclk);
      rx_line <= 1'b0;
      repeat (blen) @(posedge aclk);
      for (int i = 0; i < n; i++) begin
         rx_line <= bits[i];
         if (i == gl) begin
            // One-sample disturbance at the bit centre
            repeat (blen / 2) @(posedge aclk);
            rx_line <= ~bits[i];
            repeat (2) @(posedge aclk);
            rx_line <= bits[i];
            repeat (blen / 2 - 2) @(posedge aclk);
         end else begin
            repeat (blen) @(posedge aclk);
         end
      end
      rx_line <= stop_val;
      repeat (slen) @(posedge aclk);
      rx_line <= 1'b1;
   endtask : send

   // Short low pulse on the idle line
   task automatic spike(input int len);
      @(posedge aclk);
      rx_line <= 1'b0;
      repeat (len) @(posedge aclk);
      rx_line <= 1'b1;
   endtask : spike
endmodule : urx_tx_model
`default_nettype wire

// ==== verification/urx_receiver_tb.sv ====
// Self-checking bench for the receive front end over AXI4-Lite.
// Assumes the transmitter model drives rx_pin; divisor 1 gives 2 aclk per sample.
`timescale 1ns/100ps
`default_nettype none
module urx_receiver_tb;
   import urx_pkg::*;
   logic        aclk, aresetn;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, osc, clk_en, irq, osc_seen;
   logic [1:0]  bresp, rresp, rr, br;
   wire         rx_line;
   int          n_mismatch, check_count, n_irq, cyc;

   urx_receiver DUT (.aclk(aclk), .aresetn(aresetn), .rx_pin(rx_line),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .osc_power_req(osc), .port_clk_en(clk_en), .start_irq(irq));
   urx_tx_model TX (.aclk(aclk), .rx_line(rx_line));

   // Clock
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   // Verdict and end of run
   task automatic complete_run;
      $display("Counts: %0d compares, %0d mismatches", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   // Watchdog, start pulse count and request history
   always @(posedge aclk) begin
      cyc++;
      if (irq === 1'b1) n_irq++;
      if (osc === 1'b1 && clk_en === 1'b1) osc_seen = 1'b1;
      if (cyc == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      do @(posedge aclk); while (bvalid !== 1'b1);
      br = bresp;
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask : axi_rd

   // Read, mask and compare
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      axi_rd(a);
      chk(rd & m, e);
   endtask : rd_chk

   // Poll status until an entry is present
   task automatic wait_full;
      int k = 0;
      do begin
         axi_rd(URX_STATUS_OFS);
         k++;
      end while (rd[0] !== 1'b1 && k < 40);
   endtask : wait_full

   initial begin
      aresetn = 1'b0;
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
      {n_mismatch, check_count, n_irq, cyc, osc_seen} = '0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values, unmapped access and divisor
      rd_chk(URX_CTRL_OFS, 32'h000001FF, 32'h00000030);
      rd_chk(URX_BAUD_OFS, 32'h00000FFF, 32'h0000000C);
      rd_chk(URX_STATUS_OFS, 32'h0000003F, 32'h00000000);
      axi_rd(12'h010);
      chk(rr, URX_SLVERR);
      axi_wr(12'h010, 32'h00000001);
      chk(br, URX_SLVERR);
      axi_wr(URX_BAUD_OFS, 32'h00000001);
      chk(br, URX_OKAY);
      rd_chk(URX_BAUD_OFS, 32'h00000FFF, 32'h00000001);
      $display("Test registers done");
      // Normal speed, 8 bits, two stop bits, detector with start pulse
      axi_wr(URX_CTRL_OFS, 32'h0000003D);
      TX.send(10'h0A5, 8, 32, 64, 1'b1, -1);
      wait_full();
      chk(rd & 32'h1F, 32'h00000011);
      rd_chk(URX_DATA_OFS, 32'h000001FF, 32'h000000A5);
      chk(n_irq, 1);
      chk(osc_seen, 1'b1);
      axi_wr(URX_STATUS_OFS, 32'h00000010);
      repeat (2) @(posedge aclk);
      chk(osc, 1'b0);
      rd_chk(URX_STATUS_OFS, 32'h0000001F, 32'h00000000);
      $display("Test normal frame done");
      // Low stop bit
      TX.send(10'h03C, 8, 32, 32, 1'b0, -1);
      wait_full();
      chk(rd & 32'h0F, 32'h00000003);
      rd_chk(URX_DATA_OFS, 32'h000001FF, 32'h0000003C);
      $display("Test framing error done");
      // Noise: short start pulse, then a one-sample spike inside a bit
      TX.spike(8);
      repeat (400) @(posedge aclk);
      rd_chk(URX_STATUS_OFS, 32'h00000001, 32'h00000000);
      TX.send(10'h05A, 8, 32, 32, 1'b1, 2);
      wait_full();
      chk(rd & 32'h07, 32'h00000001);
      rd_chk(URX_DATA_OFS, 32'h000001FF, 32'h0000005A);
      $display("Test noise done");
      // Double speed, 5 bits even parity, shortest stop, detector off
      axi_wr(URX_CTRL_OFS, 32'h00000083);
      repeat (2) @(posedge aclk);
      n_irq = 0;
      osc_seen = 1'b0;
      TX.send(10'h035, 6, 16, 12, 1'b1, -1);
      TX.send(10'h00A, 6, 16, 16, 1'b1, 3);
      wait_full();
      chk(rd & 32'h0F, 32'h00000009);
      rd_chk(URX_DATA_OFS, 32'h000001FF, 32'h0000000A);
      chk(n_irq, 0);
      chk(osc_seen, 1'b0);
      axi_wr(URX_STATUS_OFS, 32'h00000008);
      rd_chk(URX_STATUS_OFS, 32'h00000008, 32'h00000000);
      $display("Test double speed done");
      // Nine bits odd parity with bad parity bit, detector without pulse
      axi_wr(URX_CTRL_OFS, 32'h000001C5);
      TX.send(10'h3C3, 10, 32, 32, 1'b1, -1);
      wait_full();
      chk(rd & 32'h07, 32'h00000005);
      chk(osc_seen, 1'b1);
      chk(osc, 1'b0);
      chk(n_irq, 0);
      rd_chk(URX_DATA_OFS, 32'h000001FF, 32'h000001C3);
      $display("Test nine bits done");
      // Receiver disabled: frame is not taken
      axi_wr(URX_CTRL_OFS, 32'h000001C4);
      TX.send(10'h1C3, 10, 32, 32, 1'b1, -1);
      repeat (40) @(posedge aclk);
      rd_chk(URX_STATUS_OFS, 32'h00000001, 32'h00000000);
      $display("Test disabled done");
      complete_run();
   end
endmodule : urx_receiver_tb
`default_nettype wire
